// [logic/call_and_load_instruction_exec.sv]
// What this block does
// - A call in extended or Y-indexed mode stacks the opcode address plus three.
// - A call in direct or X-indexed mode stacks the opcode address plus two.
// - The return address is pushed low byte first then high byte, the stack pointer dropping by one per byte.
// - The stack pointer names the next free byte, so each push writes at its current value.
// - After stacking, the program counter takes the effective address and the call leaves the flags alone.
// - Call opcodes are 9d, bd, ad and prefix 18 then ad, taking 5, 6, 6 and 7 cycles.
// - The last two call cycles write the low byte at SP and the high byte at SP minus one with read/write low.
// - Indexed modes read ffff after the offset then read index plus offset; direct calls read 00dd first.
// - An 8-bit load copies the byte at the effective address into accumulator A or B.
// - An 8-bit load sets N from bit 7, sets Z on zero, clears V and keeps the other flags.
// - Loads into A use 86, 96, b6, a6 and prefix 18 then a6.
// - Loads into B use c6, d6, f6, e6 and prefix 18 then e6.
// - 8-bit loads take 2, 3, 4, 4 and 5 cycles, all reads, with the operand read last.
// - The double load puts the byte at the effective address in A and the next byte in B.
module call_and_load_instruction_exec
  import exec_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_rdata,
  input wire logic [15:0] i_index_x,
  input wire logic [15:0] i_index_y,
  output logic [15:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_rw,
  output logic o_opcode_fetch,
  output logic o_unknown_op,
  output logic [7:0] o_accum_a,
  output logic [7:0] o_accum_b,
  output logic [7:0] o_ccr,
  output logic [15:0] o_sp,
  output logic [15:0] o_pc
);

  // Instruction class from the opcode byte; the prefix only admits indexed forms
  function automatic kind_type decode_kind(input logic [7:0] opc, input logic y_pfx);
    kind_type k;
    k = K_NONE;
    unique case (opc)
      OPC_CALL_DIR, OPC_CALL_EXT, OPC_CALL_IDX: k = K_CALL;
      OPC_LDA_IMM, OPC_LDA_DIR, OPC_LDA_EXT, OPC_LDA_IDX: k = K_LDA;
      OPC_LDB_IMM, OPC_LDB_DIR, OPC_LDB_EXT, OPC_LDB_IDX: k = K_LDB;
      OPC_LDD_IMM, OPC_LDD_DIR, OPC_LDD_EXT, OPC_LDD_IDX: k = K_LDD;
      default: k = K_NONE;
    endcase
    if (y_pfx && (opc != OPC_CALL_IDX) && (opc != OPC_LDA_IDX) && (opc != OPC_LDB_IDX) && (opc != OPC_LDD_IDX))
    begin
      k = K_NONE;
    end
    return k;
  endfunction

  // Addressing mode from the opcode byte
  function automatic mode_type decode_mode(input logic [7:0] opc);
    mode_type m;
    m = M_IMM;
    unique case (opc)
      OPC_CALL_DIR, OPC_LDA_DIR, OPC_LDB_DIR, OPC_LDD_DIR: m = M_DIR;
      OPC_CALL_EXT, OPC_LDA_EXT, OPC_LDB_EXT, OPC_LDD_EXT: m = M_EXT;
      OPC_CALL_IDX, OPC_LDA_IDX, OPC_LDB_IDX, OPC_LDD_IDX: m = M_IDX;
      default: m = M_IMM;
    endcase
    return m;
  endfunction

  state_type state_q, state_d;
  kind_type kind_q, kind_d;
  mode_type mode_q, mode_d;
  logic y_q, y_d;
  logic [15:0] pc_q, pc_d;
  logic [15:0] op_addr_q, op_addr_d;
  logic [15:0] ea_q, ea_d;
  logic [15:0] ret_q, ret_d;
  logic [15:0] sp_q, sp_d;
  logic [7:0] acc_a_q, acc_a_d;
  logic [7:0] acc_b_q, acc_b_d;
  logic [7:0] ccr_q, ccr_d;
  logic [15:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d;
  logic rw_q, rw_d;
  logic fetch_q, fetch_d;
  logic unknown_q, unknown_d;

  logic [15:0] cc_value;
  logic cc_wide;
  logic [7:0] cc_next;
  logic [15:0] index_sel;
  kind_type dec_kind;
  mode_type dec_mode;

  // Flag results for the byte arriving this cycle; only applied when a load completes
  assign cc_wide = (kind_q == K_LDD);
  assign cc_value = cc_wide ? {acc_a_q, i_rdata} : {BYTE_ZERO, i_rdata};
  assign index_sel = y_q ? i_index_y : i_index_x;
  assign dec_kind = decode_kind(i_rdata, state_q == ST_PREFIX);
  assign dec_mode = decode_mode(i_rdata);

  cc_update u_cc_update (
    .i_value(cc_value),
    .i_wide(cc_wide),
    .i_ccr(ccr_q),
    .o_ccr(cc_next)
  );

  // Sequencer: addr_q is the address of the current bus cycle, i_rdata is taken at its end.
  // Bus outputs are computed one cycle ahead so that they leave straight from flip-flops.
  always_comb
  begin
    state_d = state_q;
    kind_d = kind_q;
    mode_d = mode_q;
    y_d = y_q;
    pc_d = pc_q;
    op_addr_d = op_addr_q;
    ea_d = ea_q;
    ret_d = ret_q;
    sp_d = sp_q;
    acc_a_d = acc_a_q;
    acc_b_d = acc_b_q;
    ccr_d = ccr_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rw_d = RW_READ;
    fetch_d = 1'b0;
    unknown_d = 1'b0;
    unique case (state_q)
      ST_FETCH:
      begin
        op_addr_d = addr_q;
        pc_d = addr_q + ADDR_STEP;
        addr_d = addr_q + ADDR_STEP;
        y_d = 1'b0;
        if (i_rdata == OPC_PREFIX_Y)
        begin
          y_d = 1'b1;
          state_d = ST_PREFIX;
        end
        else if (dec_kind != K_NONE)
        begin
          kind_d = dec_kind;
          mode_d = dec_mode;
          state_d = ST_OPER1;
        end
        else
        begin
          // Foreign opcodes belong to other units; flag them and move on
          unknown_d = 1'b1;
          fetch_d = 1'b1;
          state_d = ST_FETCH;
        end
      end
      ST_PREFIX:
      begin
        pc_d = pc_q + ADDR_STEP;
        addr_d = pc_q + ADDR_STEP;
        if (dec_kind != K_NONE)
        begin
          kind_d = dec_kind;
          mode_d = dec_mode;
          state_d = ST_OPER1;
        end
        else
        begin
          unknown_d = 1'b1;
          fetch_d = 1'b1;
          state_d = ST_FETCH;
        end
      end
      ST_OPER1:
      begin
        pc_d = pc_q + ADDR_STEP;
        unique case (mode_q)
          M_IMM:
          begin
            if (kind_q == K_LDD)
            begin
              acc_a_d = i_rdata;
              addr_d = pc_q + ADDR_STEP;
              state_d = ST_OPER2;
            end
            else
            begin
              // Immediate byte is the operand; two cycles in all
              if (kind_q == K_LDA)
              begin
                acc_a_d = i_rdata;
              end
              else
              begin
                acc_b_d = i_rdata;
              end
              ccr_d = cc_next;
              addr_d = pc_q + ADDR_STEP;
              fetch_d = 1'b1;
              state_d = ST_FETCH;
            end
          end
          M_DIR:
          begin
            ea_d = {DIRECT_PAGE, i_rdata};
            addr_d = {DIRECT_PAGE, i_rdata};
            state_d = ST_MEM1;
          end
          M_EXT:
          begin
            ea_d = {i_rdata, BYTE_ZERO};
            addr_d = pc_q + ADDR_STEP;
            state_d = ST_OPER2;
          end
          M_IDX:
          begin
            // Offset is unsigned; the dummy cycle hides the adder latency
            ea_d = index_sel + {BYTE_ZERO, i_rdata};
            addr_d = DUMMY_ADDR;
            state_d = ST_DUMMY;
          end
        endcase
      end
      ST_OPER2:
      begin
        pc_d = pc_q + ADDR_STEP;
        if (mode_q == M_IMM)
        begin
          acc_b_d = i_rdata;
          ccr_d = cc_next;
          addr_d = pc_q + ADDR_STEP;
          fetch_d = 1'b1;
          state_d = ST_FETCH;
        end
        else
        begin
          ea_d = {ea_q[15:8], i_rdata};
          addr_d = {ea_q[15:8], i_rdata};
          state_d = ST_MEM1;
        end
      end
      ST_DUMMY:
      begin
        addr_d = ea_q;
        state_d = ST_MEM1;
      end
      ST_MEM1:
      begin
        unique case (kind_q)
          K_CALL:
          begin
            // Read data is discarded; the low return byte goes out next
            if ((mode_q == M_EXT) || y_q)
            begin
              ret_d = op_addr_q + RET_OFS_LONG;
            end
            else
            begin
              ret_d = op_addr_q + RET_OFS_SHORT;
            end
            wdata_d = ((mode_q == M_EXT) || y_q) ? op_addr_q[7:0] + RET_OFS_LONG[7:0] :
              op_addr_q[7:0] + RET_OFS_SHORT[7:0];
            addr_d = sp_q;
            rw_d = RW_WRITE;
            state_d = ST_PUSH_LO;
          end
          K_LDA, K_LDB:
          begin
            if (kind_q == K_LDA)
            begin
              acc_a_d = i_rdata;
            end
            else
            begin
              acc_b_d = i_rdata;
            end
            ccr_d = cc_next;
            addr_d = pc_q;
            fetch_d = 1'b1;
            state_d = ST_FETCH;
          end
          K_LDD:
          begin
            acc_a_d = i_rdata;
            addr_d = ea_q + ADDR_STEP;
            state_d = ST_MEM2;
          end
          default:
          begin
            addr_d = pc_q;
            fetch_d = 1'b1;
            state_d = ST_FETCH;
          end
        endcase
      end
      ST_MEM2:
      begin
        acc_b_d = i_rdata;
        ccr_d = cc_next;
        addr_d = pc_q;
        fetch_d = 1'b1;
        state_d = ST_FETCH;
      end
      ST_PUSH_LO:
      begin
        sp_d = sp_q - SP_STEP;
        addr_d = sp_q - SP_STEP;
        wdata_d = ret_q[15:8];
        rw_d = RW_WRITE;
        state_d = ST_PUSH_HI;
      end
      ST_PUSH_HI:
      begin
        // Flags are not touched anywhere on the call path
        sp_d = sp_q - SP_STEP;
        pc_d = ea_q;
        addr_d = ea_q;
        fetch_d = 1'b1;
        state_d = ST_FETCH;
      end
      default:
      begin
        // Illegal state code: restart at the next program byte
        addr_d = pc_q;
        fetch_d = 1'b1;
        state_d = ST_FETCH;
      end
    endcase
  end

  // Register stage; synchronous reset starts with an opcode fetch at the reset address
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      state_q <= ST_FETCH;
      kind_q <= K_NONE;
      mode_q <= M_IMM;
      y_q <= 1'b0;
      pc_q <= PC_RESET;
      op_addr_q <= PC_RESET;
      ea_q <= WORD_ZERO;
      ret_q <= WORD_ZERO;
      sp_q <= SP_RESET;
      acc_a_q <= ACC_RESET;
      acc_b_q <= ACC_RESET;
      ccr_q <= CCR_RESET;
      addr_q <= PC_RESET;
      wdata_q <= BYTE_ZERO;
      rw_q <= RW_READ;
      fetch_q <= 1'b1;
      unknown_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      kind_q <= kind_d;
      mode_q <= mode_d;
      y_q <= y_d;
      pc_q <= pc_d;
      op_addr_q <= op_addr_d;
      ea_q <= ea_d;
      ret_q <= ret_d;
      sp_q <= sp_d;
      acc_a_q <= acc_a_d;
      acc_b_q <= acc_b_d;
      ccr_q <= ccr_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rw_q <= rw_d;
      fetch_q <= fetch_d;
      unknown_q <= unknown_d;
    end
  end

  // All outputs come straight from the register stage
  assign o_addr = addr_q;
  assign o_wdata = wdata_q;
  assign o_rw = rw_q;
  assign o_opcode_fetch = fetch_q;
  assign o_unknown_op = unknown_q;
  assign o_accum_a = acc_a_q;
  assign o_accum_b = acc_b_q;
  assign o_ccr = ccr_q;
  assign o_sp = sp_q;
  assign o_pc = pc_q;

endmodule

// [logic/cc_update.sv]
module cc_update
  import exec_pkg::*;
(
  input wire logic [15:0] i_value,
  input wire logic i_wide,
  input wire logic [7:0] i_ccr,
  output logic [7:0] o_ccr
);

  // Loads touch only N, Z and V; every other bit passes through
  always_comb
  begin
    o_ccr = i_ccr;
    if (i_wide)
    begin
      o_ccr[CC_N] = i_value[15];
      o_ccr[CC_Z] = (i_value == WORD_ZERO);
    end
    else
    begin
      o_ccr[CC_N] = i_value[7];
      o_ccr[CC_Z] = (i_value[7:0] == BYTE_ZERO);
    end
    o_ccr[CC_V] = 1'b0;
  end

endmodule

// [logic/exec_pkg.sv]
package exec_pkg;

  // Opcodes of the three instruction groups
  localparam logic [7:0] OPC_PREFIX_Y = 8'h18;
  localparam logic [7:0] OPC_CALL_DIR = 8'h9d;
  localparam logic [7:0] OPC_CALL_EXT = 8'hbd;
  localparam logic [7:0] OPC_CALL_IDX = 8'had;
  localparam logic [7:0] OPC_LDA_IMM = 8'h86;
  localparam logic [7:0] OPC_LDA_DIR = 8'h96;
  localparam logic [7:0] OPC_LDA_EXT = 8'hb6;
  localparam logic [7:0] OPC_LDA_IDX = 8'ha6;
  localparam logic [7:0] OPC_LDB_IMM = 8'hc6;
  localparam logic [7:0] OPC_LDB_DIR = 8'hd6;
  localparam logic [7:0] OPC_LDB_EXT = 8'hf6;
  localparam logic [7:0] OPC_LDB_IDX = 8'he6;
  localparam logic [7:0] OPC_LDD_IMM = 8'hcc;
  localparam logic [7:0] OPC_LDD_DIR = 8'hdc;
  localparam logic [7:0] OPC_LDD_EXT = 8'hfc;
  localparam logic [7:0] OPC_LDD_IDX = 8'hec;

  // Bus and address constants
  localparam logic [15:0] DUMMY_ADDR = 16'hffff;
  localparam logic [7:0] DIRECT_PAGE = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] ADDR_STEP = 16'h0001;
  localparam logic [15:0] SP_STEP = 16'h0001;
  localparam logic [15:0] RET_OFS_LONG = 16'h0003;
  localparam logic [15:0] RET_OFS_SHORT = 16'h0002;
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;

  // Condition code bit positions (S X H I N Z V C)
  localparam int CC_N = 3;
  localparam int CC_Z = 2;
  localparam int CC_V = 1;

  // Reset values; plain defaults, vector fetch is handled elsewhere
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h00ff;
  localparam logic [7:0] CCR_RESET = 8'h00;
  localparam logic [7:0] ACC_RESET = 8'h00;

  // One bus cycle per state
  typedef enum logic [3:0] {
    ST_FETCH = 4'h0,
    ST_PREFIX = 4'h1,
    ST_OPER1 = 4'h2,
    ST_OPER2 = 4'h3,
    ST_DUMMY = 4'h4,
    ST_MEM1 = 4'h5,
    ST_MEM2 = 4'h6,
    ST_PUSH_LO = 4'h7,
    ST_PUSH_HI = 4'h8
  } state_type;

  typedef enum logic [2:0] {
    K_NONE = 3'h0,
    K_CALL = 3'h1,
    K_LDA = 3'h2,
    K_LDB = 3'h3,
    K_LDD = 3'h4
  } kind_type;

  typedef enum logic [1:0] {
    M_IMM = 2'h0,
    M_DIR = 2'h1,
    M_EXT = 2'h2,
    M_IDX = 2'h3
  } mode_type;

endpackage

// [test/bus_memory.sv]
module bus_memory
(
  input wire logic i_clock,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_rw,
  output logic [7:0] o_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:65535];

  // Zero wait states, so read data follows the address within the cycle
  assign o_rdata = mem[i_addr];

  // A write lands on the edge that closes its cycle
  always @(posedge i_clock)
  begin
    if (i_rw == 1'b0)
    begin
      mem[i_addr] <= i_wdata;
    end
  end
endmodule

// [test/call_and_load_instruction_exec_test.sv]
module call_and_load_instruction_exec_test
  import exec_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [15:0] i_index_x = 16'h2000;
  logic [15:0] i_index_y = 16'h3000;
  logic [7:0] rdata, wdata, acc_a, acc_b, ccr;
  logic [15:0] addr, sp, pc;
  logic rw, fetch, unknown;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [7:0] ops [4][4] = '{'{OPC_LDA_IMM, OPC_LDA_DIR, OPC_LDA_EXT, OPC_LDA_IDX},
    '{OPC_LDB_IMM, OPC_LDB_DIR, OPC_LDB_EXT, OPC_LDB_IDX}, '{OPC_LDD_IMM, OPC_LDD_DIR, OPC_LDD_EXT, OPC_LDD_IDX},
    '{8'h00, OPC_CALL_DIR, OPC_CALL_EXT, OPC_CALL_IDX}};
  int base [4] = '{2, 3, 4, 4};

  call_and_load_instruction_exec i_dut (.i_clock, .i_sys_rst, .i_rdata(rdata), .i_index_x, .i_index_y,
    .o_addr(addr), .o_wdata(wdata), .o_rw(rw), .o_opcode_fetch(fetch), .o_unknown_op(unknown),
    .o_accum_a(acc_a), .o_accum_b(acc_b), .o_ccr(ccr), .o_sp(sp), .o_pc(pc));
  bus_memory i_mem (.i_clock, .i_addr(addr), .i_wdata(wdata), .i_rw(rw), .o_rdata(rdata));

  // 40 MHz clock
  initial
  begin
    forever #12.5 i_clock = ~i_clock;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at time %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (fails == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hang guard, far above the roughly 660 cycles the tests need
  always @(posedge i_clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  // Flags expected from a clean CCR, as every run starts from reset
  function automatic logic [7:0] flags(input logic [15:0] v, input bit wide);
    logic [7:0] f;
    f = 8'h00;
    f[CC_N] = wide ? v[15] : v[7];
    f[CC_Z] = wide ? (v == 16'h0000) : (v[7:0] == 8'h00);
    return f;
  endfunction

  // Short reset with fresh index values; returns at the edge where cycle 0 begins
  task automatic start();
    @(posedge i_clock);
    i_sys_rst <= 1'b1;
    i_index_x <= 16'($urandom_range(8192, 28671));
    i_index_y <= 16'($urandom_range(8192, 28671));
    @(posedge i_clock);
    i_sys_rst <= 1'b0;
  endtask

  // One load of A with pre, then the instruction under test at address 2 (prefix there when yy)
  task automatic run(input int k, input int m, input int yy, input logic [7:0] pre, input logic [15:0] v);
    logic [15:0] ea;
    logic [15:0] ret;
    logic [7:0] off;
    int p;
    int cyc;
    start();
    p = 2 + yy;
    off = 8'($urandom);
    ret = 16'(p + ((m == 2 || (m == 0 && k == 2)) ? 3 : 2));
    cyc = base[m] + yy + (k == 2) + 2 * (k == 3);
    case (m)
      0: ea = 16'(p + 1);
      1: ea = {8'h00, 8'($urandom_range(32, 239))};
      2: ea = 16'($urandom_range(4096, 32767));
      default: ea = (yy ? i_index_y : i_index_x) + {8'h00, off};
    endcase
    i_mem.mem[0] = OPC_LDA_IMM;
    i_mem.mem[1] = pre;
    i_mem.mem[2] = OPC_PREFIX_Y;
    i_mem.mem[p] = ops[k][m];
    i_mem.mem[p + 1] = m == 2 ? ea[15:8] : m == 1 ? ea[7:0] : off;
    i_mem.mem[p + 2] = ea[7:0];
    i_mem.mem[ea] = k == 2 ? v[15:8] : v[7:0];
    i_mem.mem[ea + 16'h0001] = v[7:0];
    i_mem.mem[16'hffff] = 8'($urandom);
    // Stack bytes start as the inverse of what a call must leave, so a lost push shows up
    i_mem.mem[16'h00ff] = ~ret[7:0];
    i_mem.mem[16'h00fe] = ~ret[15:8];
    repeat (1 + cyc) @(posedge i_clock);
    #1;
    check(fetch, 1'b0);
    @(posedge i_clock);
    #1;
    check({fetch, addr}, {1'b1, (k == 3 ? ea : ret)});
    check(pc, k == 3 ? ea : ret);
    check(acc_a, k == 0 ? v[7:0] : k == 2 ? v[15:8] : pre);
    check(acc_b, k == 1 || k == 2 ? v[7:0] : ACC_RESET);
    check(ccr, k == 3 ? flags({8'h00, pre}, 1'b0) : flags(v, k == 2));
    if (k == 3)
    begin
      check(i_mem.mem[16'h00ff], ret[7:0]);
      check(i_mem.mem[16'h00fe], ret[15:8]);
      check(sp, SP_RESET - 16'h0002);
    end
  endtask

  // An opcode outside this block is skipped as a bare fetch
  task automatic bad(input logic [7:0] b0, input logic [7:0] b1, input int n);
    start();
    i_mem.mem[0] = b0;
    i_mem.mem[1] = b1;
    repeat (n) @(posedge i_clock);
    #1;
    check({unknown, fetch, addr}, {2'b11, 16'(n)});
  endtask

  // Corner rounds first (zero, low byte negative, high byte only), then random data
  initial
  begin
    void'($urandom(36));
    repeat (20) @(posedge i_clock);
    #1;
    check({sp, ccr, acc_a}, {SP_RESET, CCR_RESET, ACC_RESET});
    check({addr, acc_b, rw, fetch, unknown}, {16'h0000, ACC_RESET, 3'b110});
    for (int r = 0; r < 4; r++)
      for (int k = 0; k < 4; k++)
        for (int m = 0; m < 4; m++)
          for (int yy = 0; yy < 2; yy++)
            if (!(yy == 1 && m != 3) && !(k == 3 && m == 0))
              run(k, m, yy, r == 0 ? 8'h80 : 8'($urandom),
                r == 0 ? 16'h0000 : r == 1 ? 16'h0081 : r == 2 ? 16'h8000 : 16'($urandom));
    bad(8'h01, 8'h01, 1);
    bad(OPC_PREFIX_Y, OPC_LDA_IMM, 2);
    tally_and_finish();
  end
endmodule

// [test/exec_assertions.sv]
module exec_assertions
  import exec_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_rdata,
  input wire logic [15:0] i_index_x,
  input wire logic [15:0] i_index_y,
  input wire logic [15:0] o_addr,
  input wire logic [7:0] o_wdata,
  input wire logic o_rw,
  input wire logic o_opcode_fetch,
  input wire logic o_unknown_op,
  input wire logic [7:0] o_accum_a,
  input wire logic [7:0] o_accum_b,
  input wire logic [7:0] o_ccr,
  input wire logic [15:0] o_sp,
  input wire logic [15:0] o_pc
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);

  // Stacking: the first write goes where the pointer stands, the second one below
  AST_PUSH_AT_SP: assert property ($fell(o_rw) |-> o_addr == o_sp)
    else $error("first push not at stack pointer");
  AST_PUSH_PAIR: assert property ($fell(o_rw) |=>
    !o_rw && o_addr == $past(o_addr) - SP_STEP ##1 o_rw && o_opcode_fetch)
    else $error("push pair malformed");
  AST_SP_DROP: assert property ($fell(o_rw) |-> ##2 o_sp == $past(o_addr, 2) - 16'h0002)
    else $error("stack pointer not lowered by two");
  AST_CALL_FLAGS: assert property ($fell(o_rw) |-> ##2 o_ccr == $past(o_ccr, 2))
    else $error("call changed flags");
  // Only N, Z and V may ever move in this block
  AST_FLAGS_KEEP: assert property (((o_ccr ^ $past(o_ccr)) & 8'hf1) == 8'h00)
    else $error("flag outside N Z V changed");
  // Wrong offset or index shows as a wrong address right after the dummy read
  AST_DUMMY_THEN_INDEX: assert property (o_addr == DUMMY_ADDR && !o_opcode_fetch |=>
    o_rw && !o_opcode_fetch &&
    (o_addr == $past(i_index_x, 2) + {8'h00, $past(i_rdata, 2)} ||
     o_addr == $past(i_index_y, 2) + {8'h00, $past(i_rdata, 2)}))
    else $error("indexed read address wrong");
  AST_FETCH_GAP: assert property (o_opcode_fetch |-> ##[1:7] o_opcode_fetch)
    else $error("instruction too long");
  AST_UNKNOWN_SKIP: assert property (o_unknown_op |-> o_opcode_fetch && o_addr == $past(o_addr) + ADDR_STEP)
    else $error("unknown opcode not skipped");
  // Reset edge is excluded, as the accumulators clear there without a read
  AST_ACC_A: assert property ($changed(o_accum_a) && !$past(i_sys_rst) |->
    $past(o_rw) && o_accum_a == $past(i_rdata))
    else $error("accumulator A not from read data");
  AST_ACC_B: assert property ($changed(o_accum_b) && !$past(i_sys_rst) |->
    o_accum_b == $past(i_rdata) && !o_ccr[CC_V])
    else $error("accumulator B or V wrong");
endmodule

bind call_and_load_instruction_exec exec_assertions i_chk (.i_clock, .i_sys_rst, .i_rdata, .i_index_x,
  .i_index_y, .o_addr, .o_wdata, .o_rw, .o_opcode_fetch, .o_unknown_op, .o_accum_a, .o_accum_b, .o_ccr,
  .o_sp, .o_pc);
